// ---- core/sfb_front_end.sv ----
// Serial bus front end of a small serial flash device
`timescale 1ns/10ps
`include "sfb_regs.svh"

module sfb_front_end
  import sfb_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             cs_n,
  input  wire logic             sck,
  input  wire logic             si_in,
  output logic                  si_out,
  output logic                  si_oe,
  output logic                  so_out,
  output logic                  so_oe,
  input  wire logic             hold_n,
  input  wire logic             wp_n,
  input  wire logic             out_en,
  input  wire logic             dual_en,
  input  wire logic             busy,
  output logic      [7:0]       rx_data,
  output logic                  rx_first,
  output logic                  rx_valid,
  input  wire logic             rx_ready,
  output logic                  rx_overrun,
  input  wire logic [7:0]       tx_data,
  input  wire logic             tx_valid,
  output logic                  tx_ready,
  output logic                  selected,
  output logic                  standby,
  output logic                  write_lock,
  output sfb_pkg::sfb_erase_t   erase_kind
);
  import sfb_pkg::*;
  localparam int            NP       = `SFB_PIN_COUNT;
  localparam logic [NP-1:0] SYNC_RST = `SFB_SYNC_RST;
  logic [NP-1:0] s1_ff;
  logic [NP-1:0] s2_ff;
  logic [NP-1:0] s3_ff;
  logic [NP-1:0] filt_ff;
  logic          sck_prev_ff;
  sfb_state_t    state_ff;
  sfb_state_t    nxt_state;
  logic [7:0]    rx_sh_ff;
  logic [2:0]    rx_cnt_ff;
  logic          first_ff;
  logic [8:0]    pend_data_ff;
  logic          pend_ff;
  logic          overrun_ff;
  sfb_erase_t    erase_ff;
  logic [7:0]    tx_sh_ff;
  logic [2:0]    tx_cnt_ff;
  logic [7:0]    tx_hold_ff;
  logic          tx_ready_ff;
  logic          so_out_ff;
  logic          si_out_ff;
  logic          so_oe_ff;
  logic          si_oe_ff;
  logic          selected_ff;
  logic          standby_ff;
  logic          lock_ff;
  logic          cs_act;
  logic          hold_act;
  logic          live;
  logic          frame_start;
  logic          rise_ok;
  logic          fall_ok;
  logic          byte_done;
  logic          launch;
  logic [7:0]    cur_word;
  logic [2:0]    step;
  logic          buf_in_ready;

  // Pin synchronisers; pause and write-lock sit high from reset, as if pulled up
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!nrst) begin
          s1_ff[gi]   <= SYNC_RST[gi];
          s2_ff[gi]   <= SYNC_RST[gi];
          s3_ff[gi]   <= SYNC_RST[gi];
          filt_ff[gi] <= SYNC_RST[gi];
        end else begin
          s1_ff[gi] <= (gi == `SFB_PIN_CS)   ? cs_n :
                       (gi == `SFB_PIN_SCK)  ? sck :
                       (gi == `SFB_PIN_SI)   ? si_in :
                       (gi == `SFB_PIN_HOLD) ? hold_n : wp_n;
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          // Only a level seen twice counts, so one glitch on the link is dropped
          if (s2_ff[gi] == s3_ff[gi]) begin
            filt_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  assign cs_act      = !filt_ff[`SFB_PIN_CS];
  assign hold_act    = cs_act && !filt_ff[`SFB_PIN_HOLD];
  assign live        = (state_ff == SFB_ST_SELECTED) && cs_act && !hold_act;
  assign frame_start = cs_act && (state_ff != SFB_ST_SELECTED) && (state_ff != SFB_ST_PAUSED);
  assign rise_ok     = live && filt_ff[`SFB_PIN_SCK] && !sck_prev_ff;
  assign fall_ok     = live && !filt_ff[`SFB_PIN_SCK] && sck_prev_ff;
  assign byte_done   = rise_ok && (rx_cnt_ff == `SFB_LAST_BIT);
  // Mode 3 starts with clock high, so a falling edge before any data is harmless
  assign launch      = fall_ok && out_en;
  assign step        = dual_en ? `SFB_STEP_DUAL : `SFB_STEP_SINGLE;
  assign cur_word    = (tx_cnt_ff != `SFB_BIT_CNT_RST) ? tx_sh_ff :
                       (tx_ready_ff ? `SFB_FILL_BYTE : tx_hold_ff);

  // Clock edge history keeps running in a pause, so release makes no false edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sck_prev_ff <= 1'b0;
    end else begin
      sck_prev_ff <= filt_ff[`SFB_PIN_SCK];
    end
  end

  // Frame state; busy only delays standby, never the serial side
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SFB_ST_STANDBY: begin
        if (cs_act) nxt_state = SFB_ST_SELECTED;
      end
      SFB_ST_SELECTED: begin
        if (!cs_act) nxt_state = busy ? SFB_ST_DRAIN : SFB_ST_STANDBY;
        else if (hold_act) nxt_state = SFB_ST_PAUSED;
      end
      SFB_ST_PAUSED: begin
        if (!cs_act) nxt_state = busy ? SFB_ST_DRAIN : SFB_ST_STANDBY;
        else if (!hold_act) nxt_state = SFB_ST_SELECTED;
      end
      SFB_ST_DRAIN: begin
        if (cs_act) nxt_state = SFB_ST_SELECTED;
        else if (!busy) nxt_state = SFB_ST_STANDBY;
      end
      default: nxt_state = SFB_ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= SFB_ST_STANDBY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Receive shifter; a pause freezes it in place rather than clearing it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_sh_ff  <= `SFB_BYTE_RST;
      rx_cnt_ff <= `SFB_BIT_CNT_RST;
      first_ff  <= 1'b1;
    end else if (frame_start) begin
      rx_cnt_ff <= `SFB_BIT_CNT_RST;
      first_ff  <= 1'b1;
    end else if (rise_ok) begin
      rx_sh_ff  <= {rx_sh_ff[6:0], filt_ff[`SFB_PIN_SI]};
      rx_cnt_ff <= rx_cnt_ff + `SFB_STEP_SINGLE;
      if (byte_done) first_ff <= 1'b0;
    end
  end

  // Finished byte waits here until the buffer takes it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_data_ff <= '0;
      pend_ff      <= 1'b0;
      overrun_ff   <= 1'b0;
    end else begin
      if (byte_done) begin
        pend_data_ff <= {first_ff, rx_sh_ff[6:0], filt_ff[`SFB_PIN_SI]};
        pend_ff      <= 1'b1;
      end else if (pend_ff && buf_in_ready) begin
        pend_ff <= 1'b0;
      end
      // A byte landing on an untaken one is flagged; the flag lives for the frame
      if (byte_done && pend_ff && !buf_in_ready) begin
        overrun_ff <= 1'b1;
      end else if (frame_start) begin
        overrun_ff <= 1'b0;
      end
    end
  end

  // Opcode names the erase size for the command layer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      erase_ff <= SFB_ER_NONE;
    end else if (frame_start) begin
      erase_ff <= SFB_ER_NONE;
    end else if (byte_done && first_ff) begin
      erase_ff <= sfb_erase_kind({rx_sh_ff[6:0], filt_ff[`SFB_PIN_SI]});
    end
  end

  // Transmit holding register, filled by the user
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_hold_ff  <= `SFB_BYTE_RST;
      tx_ready_ff <= 1'b1;
    end else if (tx_valid && tx_ready_ff) begin
      tx_hold_ff  <= tx_data;
      tx_ready_ff <= 1'b0;
    end else if (launch && (tx_cnt_ff == `SFB_BIT_CNT_RST)) begin
      tx_ready_ff <= 1'b1;
    end
  end

  // Transmit shifter; one or two bits per falling edge, MSB first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_sh_ff  <= `SFB_BYTE_RST;
      tx_cnt_ff <= `SFB_BIT_CNT_RST;
      so_out_ff <= 1'b0;
      si_out_ff <= 1'b0;
    end else if (frame_start) begin
      tx_cnt_ff <= `SFB_BIT_CNT_RST;
    end else if (launch) begin
      so_out_ff <= cur_word[7];
      si_out_ff <= cur_word[6];
      tx_sh_ff  <= dual_en ? {cur_word[5:0], 2'b00} : {cur_word[6:0], 1'b0};
      tx_cnt_ff <= tx_cnt_ff + step;
    end
  end

  // Drivers follow select and pause directly; lower lane needs the host off it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      so_oe_ff <= 1'b0;
      si_oe_ff <= 1'b0;
    end else begin
      so_oe_ff <= (nxt_state == SFB_ST_SELECTED) && !hold_act && out_en;
      si_oe_ff <= (nxt_state == SFB_ST_SELECTED) && !hold_act && out_en && dual_en;
    end
  end

  // Status levels for the command layer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      selected_ff <= 1'b0;
      standby_ff  <= 1'b1;
      lock_ff     <= 1'b0;
    end else begin
      selected_ff <= cs_act;
      standby_ff  <= (nxt_state == SFB_ST_STANDBY);
      lock_ff     <= !filt_ff[`SFB_PIN_WP];
    end
  end

  sfb_skid2 #(
    .WIDTH (9)
  ) i_sfb_skid2 (
    .clk       (clk),
    .nrst      (nrst),
    .in_data   (pend_data_ff),
    .in_valid  (pend_ff),
    .in_ready  (buf_in_ready),
    .out_data  ({rx_first, rx_data}),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  assign so_out     = so_out_ff;
  assign si_out     = si_out_ff;
  assign so_oe      = so_oe_ff;
  assign si_oe      = si_oe_ff;
  assign rx_overrun = overrun_ff;
  assign tx_ready   = tx_ready_ff;
  assign selected   = selected_ff;
  assign standby    = standby_ff;
  assign write_lock = lock_ff;
  assign erase_kind = erase_ff;

endmodule

// ---- core/sfb_pkg.sv ----
// Types of the serial flash bus front end
`include "sfb_regs.svh"

package sfb_pkg;

  // Frame state of the serial port
  typedef enum logic [1:0] {
    SFB_ST_STANDBY  = 2'b00,
    SFB_ST_SELECTED = 2'b01,
    SFB_ST_PAUSED   = 2'b10,
    SFB_ST_DRAIN    = 2'b11
  } sfb_state_t;

  // Erase granularity named by an opcode
  typedef enum logic [2:0] {
    SFB_ER_NONE   = 3'b000,
    SFB_ER_PAGE   = 3'b001,
    SFB_ER_BLK4K  = 3'b010,
    SFB_ER_BLK32K = 3'b011,
    SFB_ER_CHIP   = 3'b100
  } sfb_erase_t;

  // Map an opcode to its erase granularity
  function automatic sfb_erase_t sfb_erase_kind(input logic [7:0] opc);
    case (opc)
      `SFB_OPC_PAGE_ERASE:  sfb_erase_kind = SFB_ER_PAGE;
      `SFB_OPC_BLK4K_ERASE: sfb_erase_kind = SFB_ER_BLK4K;
      `SFB_OPC_BLK32K_A,
      `SFB_OPC_BLK32K_B:    sfb_erase_kind = SFB_ER_BLK32K;
      `SFB_OPC_CHIP_A,
      `SFB_OPC_CHIP_B,
      `SFB_OPC_CHIP_LEGACY: sfb_erase_kind = SFB_ER_CHIP;
      default:              sfb_erase_kind = SFB_ER_NONE;
    endcase
  endfunction

endpackage

// ---- core/sfb_regs.svh ----
// Constants of the serial flash bus front end
`ifndef SFB_REGS_SVH
`define SFB_REGS_SVH

// Positions of the sampled pins in the synchroniser vector
`define SFB_PIN_CS        0
`define SFB_PIN_SCK       1
`define SFB_PIN_SI        2
`define SFB_PIN_HOLD      3
`define SFB_PIN_WP        4
`define SFB_PIN_COUNT     5

// Synchroniser reset values: select, pause and write-lock idle high
`define SFB_SYNC_RST      5'h19

// Byte framing
`define SFB_BYTE_BITS     8
`define SFB_BIT_CNT_RST   3'h0
`define SFB_LAST_BIT      3'h7
`define SFB_STEP_SINGLE   3'h1
`define SFB_STEP_DUAL     3'h2

// Byte shifted out when the user has nothing queued
`define SFB_FILL_BYTE     8'hff
`define SFB_BYTE_RST      8'h00

// Erase opcodes; 32K block erase has two and chip erase has three
`define SFB_OPC_PAGE_ERASE   8'h81
`define SFB_OPC_BLK4K_ERASE  8'h20
`define SFB_OPC_BLK32K_A     8'h52
`define SFB_OPC_BLK32K_B     8'hd8
`define SFB_OPC_CHIP_A       8'h60
`define SFB_OPC_CHIP_B       8'hc7
`define SFB_OPC_CHIP_LEGACY  8'h62

`endif

// ---- core/sfb_skid2.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps

module sfb_skid2 #(
  parameter int WIDTH = 9
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] q0_ff;
  logic [WIDTH-1:0] q1_ff;
  logic             v0_ff;
  logic             v1_ff;
  logic             rdy_ff;
  logic             push;
  logic             pop;
  logic             nxt_v0;
  logic             nxt_v1;

  assign push      = in_valid && rdy_ff;
  assign pop       = v0_ff && out_ready;
  assign in_ready  = rdy_ff;
  assign out_data  = q0_ff;
  assign out_valid = v0_ff;

  // Occupancy; head entry always drains first
  always_comb begin
    nxt_v0 = v0_ff;
    nxt_v1 = v1_ff;
    case ({push, pop})
      2'b10: begin
        if (v0_ff) begin
          nxt_v1 = 1'b1;
        end else begin
          nxt_v0 = 1'b1;
        end
      end
      2'b01: begin
        nxt_v0 = v1_ff;
        nxt_v1 = 1'b0;
      end
      default: begin
        nxt_v0 = v0_ff;
        nxt_v1 = v1_ff;
      end
    endcase
  end

  // Flags; ready is registered so it reads full honestly
  always_ff @(posedge clk) begin
    if (!nrst) begin
      v0_ff  <= 1'b0;
      v1_ff  <= 1'b0;
      rdy_ff <= 1'b1;
    end else begin
      v0_ff  <= nxt_v0;
      v1_ff  <= nxt_v1;
      rdy_ff <= !nxt_v1;
    end
  end

  // Entry data
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q0_ff <= '0;
      q1_ff <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (v0_ff) begin
            q1_ff <= in_data;
          end else begin
            q0_ff <= in_data;
          end
        end
        2'b01: begin
          q0_ff <= q1_ff;
        end
        2'b11: begin
          if (v1_ff) begin
            q0_ff <= q1_ff;
            q1_ff <= in_data;
          end else begin
            q0_ff <= in_data;
          end
        end
        default: begin
          q0_ff <= q0_ff;
        end
      endcase
    end
  end

endmodule

// ---- dv/sfb_front_end_props.sv ----
// Port assertions of the serial flash bus front end
`timescale 1ns/10ps

module sfb_front_end_props (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       cs_n,
  input wire logic       hold_n,
  input wire logic       wp_n,
  input wire logic       busy,
  input wire logic       dual_en,
  input wire logic       so_oe,
  input wire logic       si_oe,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       selected,
  input wire logic       standby,
  input wire logic       write_lock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Six cycles cover the pin filter plus the output register
  cs_rel_a: assert property (cs_n[*6] |-> !so_oe && !si_oe)
    else $error("lane driven while deselected");
  hold_rel_a: assert property (!hold_n[*6] |-> !so_oe && !si_oe)
    else $error("lane driven while paused");
  dual_only_a: assert property (!dual_en[*3] |-> !si_oe)
    else $error("low lane driven outside dual phase");
  dual_pair_a: assert property (si_oe |-> so_oe)
    else $error("low lane driven without high lane");
  sel_on_a: assert property (!cs_n[*6] |-> selected)
    else $error("select not seen");
  sel_off_a: assert property (cs_n[*6] |-> !selected)
    else $error("select seen while high");
  // Busy may rise just after the decision, so two cycles are accepted
  drain_a: assert property ($rose(standby) |-> !$past(busy) || !$past(busy, 2))
    else $error("standby entered while busy");
  lock_on_a: assert property (!wp_n[*6] |-> write_lock)
    else $error("write lock not asserted");
  lock_off_a: assert property (wp_n[*6] |-> !write_lock)
    else $error("write lock asserted while high");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("receive head changed while stalled");
  tx_take_a: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("send buffer still ready after take");

  dual_c: cover property (si_oe);
  hold_c: cover property (!hold_n && selected);
  stall_c: cover property (rx_valid && !rx_ready ##1 rx_valid && !rx_ready);
  drain_c: cover property (busy && cs_n && !standby);
endmodule

bind sfb_front_end sfb_front_end_props i_sfb_front_end_props (
  .clk (clk), .nrst (nrst), .cs_n (cs_n), .hold_n (hold_n), .wp_n (wp_n), .busy (busy),
  .dual_en (dual_en), .so_oe (so_oe), .si_oe (si_oe), .rx_data (rx_data), .rx_valid (rx_valid),
  .rx_ready (rx_ready), .tx_valid (tx_valid), .tx_ready (tx_ready), .selected (selected),
  .standby (standby), .write_lock (write_lock)
);

// ---- dv/sfb_host_model.sv ----
// Behavioural host master of the serial flash bus
`timescale 1ns/10ps

module sfb_host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      si_in,
  output logic      hold_n,
  input  wire logic si_out,
  input  wire logic si_oe,
  input  wire logic so_out,
  input  wire logic so_oe
);
  logic h_si, h_oe, tgl, so_line;

  // Released lines wobble so a stale bit never reads as valid
  always @(posedge clk) tgl <= ~tgl;
  assign si_in   = si_oe ? si_out : (h_oe ? h_si : tgl);
  assign so_line = so_oe ? so_out : ~tgl;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    hold_n = 1'b1;
    h_si = 1'b0;
    h_oe = 1'b1;
    tgl = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Clock idles at the mode level before select falls
  task automatic start(input logic md3);
    sck <= md3;
    wt(2);
    cs_n <= 1'b0;
    wt(8);
  endtask

  task automatic stop(input logic md3);
    if (!md3) begin
      sck <= 1'b0;
      wt(4);
    end
    cs_n <= 1'b1;
    wt(8);
  endtask

  // One byte: fall, set data, rise, sample late so a slow launch is seen
  task automatic xfer(input logic [7:0] mo, input logic dual, input int hold_at, output logic [7:0] mi);
    int n;
    n = dual ? 4 : 8;
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      h_oe <= !dual;
      h_si <= mo[7-i];
      wt(4);
      if (i == hold_at) begin
        hold_n <= 1'b0;
        h_si <= ~mo[7-i];
        wt(6);
        repeat (2) begin
          sck <= 1'b1;
          wt(4);
          sck <= 1'b0;
          wt(4);
        end
        h_si <= mo[7-i];
        hold_n <= 1'b1;
        wt(6);
      end
      sck <= 1'b1;
      wt(4);
      mi = dual ? {mi[5:0], so_line, si_in} : {mi[6:0], so_line};
    end
  endtask
endmodule

// ---- dv/tb_sfb_front_end.sv ----
// Self-checking bench of the serial flash bus front end
`timescale 1ns/10ps
`include "sfb_regs.svh"

module tb_sfb_front_end;
  import sfb_pkg::*;

  typedef struct packed {logic first; sfb_erase_t kind; logic [7:0] data;} sfb_exp_t;

  logic        clk, nrst, cs_n, sck, si_in, si_out, si_oe, so_out, so_oe, hold_n, wp_n;
  logic        out_en, dual_en, busy, rx_first, rx_valid, rx_ready, rx_overrun;
  logic        tx_valid, tx_ready, selected, standby, write_lock, stall;
  logic [7:0]  rx_data, tx_data;
  sfb_erase_t  erase_kind;
  sfb_exp_t    e, exp_q[$];
  logic [31:0] seed = 32'hc9c4;
  logic [7:0]  opcs [8] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h62, 8'h3b};
  int          error_cnt, checked;

  sfb_front_end i_sfb_front_end (
    .clk (clk), .nrst (nrst), .cs_n (cs_n), .sck (sck), .si_in (si_in), .si_out (si_out),
    .si_oe (si_oe), .so_out (so_out), .so_oe (so_oe), .hold_n (hold_n), .wp_n (wp_n),
    .out_en (out_en), .dual_en (dual_en), .busy (busy), .rx_data (rx_data), .rx_first (rx_first),
    .rx_valid (rx_valid), .rx_ready (rx_ready), .rx_overrun (rx_overrun), .tx_data (tx_data),
    .tx_valid (tx_valid), .tx_ready (tx_ready), .selected (selected), .standby (standby),
    .write_lock (write_lock), .erase_kind (erase_kind)
  );
  sfb_host_model i_host (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic sfb_erase_t kind_of(input logic [7:0] o);
    case (o)
      8'h81: return SFB_ER_PAGE;
      8'h20: return SFB_ER_BLK4K;
      8'h52, 8'hd8: return SFB_ER_BLK32K;
      8'h60, 8'hc7, 8'h62: return SFB_ER_CHIP;
      default: return SFB_ER_NONE;
    endcase
  endfunction

  task automatic chk8(input string nm, input logic [7:0] ex, input logic [7:0] got);
    checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic conclude();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Reader stalls at random, and fully while the buffer is being filled
  always @(posedge clk) rx_ready <= !stall && (xs() > 8'h3f);

  // Each received byte is matched with the oldest note
  always @(posedge clk) begin
    if (nrst && rx_valid === 1'b1 && rx_ready === 1'b1) begin
      // A byte with no note is an extra byte and always a mismatch
      chk8("rx_queue", 8'h01, {7'h00, exp_q.size() != 0});
      if (exp_q.size() != 0) begin
        e = exp_q.pop_front();
        chk8("rx_data", e.data, rx_data);
        chk8("rx_first", {7'h00, e.first}, {7'h00, rx_first});
        if (e.first) chk8("erase_kind", 8'(e.kind), 8'(erase_kind));
      end
    end
  end

  task automatic frame(input logic [7:0] opc, input logic md3, input int hold_at, input int n);
    logic [7:0] d, mi;
    exp_q.push_back(sfb_exp_t'{1'b1, kind_of(opc), opc});
    i_host.start(md3);
    i_host.xfer(opc, 1'b0, -1, mi);
    repeat (n) begin
      d = xs();
      exp_q.push_back(sfb_exp_t'{1'b0, SFB_ER_NONE, d});
      i_host.xfer(d, 1'b0, hold_at, mi);
    end
    i_host.stop(md3);
  endtask

  task automatic offer(input logic [7:0] d);
    int k = 0;
    tx_data <= d;
    tx_valid <= 1'b1;
    do @(negedge clk); while (tx_ready !== 1'b1 && ++k < 40);
    chk8("tx_ready_wait", 8'h01, {7'h00, tx_ready});
    @(posedge clk);
    tx_valid <= 1'b0;
  endtask

  // Read frame; with nothing offered the fill byte must come back
  task automatic rd(input logic md3, input logic dual, input int hold_at, input logic give);
    logic [7:0] d, mi;
    d = give ? xs() : `SFB_FILL_BYTE;
    if (give) offer(d);
    exp_q.push_back(sfb_exp_t'{1'b1, SFB_ER_NONE, 8'h3b});
    i_host.start(md3);
    i_host.xfer(8'h3b, 1'b0, -1, mi);
    // Single mode also receives the host's zero byte; dual clocks only half a byte in
    if (!dual) exp_q.push_back(sfb_exp_t'{1'b0, SFB_ER_NONE, 8'h00});
    out_en <= 1'b1;
    dual_en <= dual;
    i_host.xfer(8'h00, dual, hold_at, mi);
    out_en <= 1'b0;
    dual_en <= 1'b0;
    i_host.stop(md3);
    chk8("read_byte", d, mi);
  endtask

  initial begin
    nrst = 1'b0;
    wp_n = 1'b1;
    out_en = 1'b0;
    dual_en = 1'b0;
    busy = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    stall = 1'b0;
    rx_ready = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk8("standby_rst", 8'h01, {7'h00, standby});
    chk8("so_oe_rst", 8'h00, {7'h00, so_oe});
    chk8("tx_ready_rst", 8'h01, {7'h00, tx_ready});
    @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    foreach (opcs[i]) frame(opcs[i], i[0], (i == 2) ? 3 : -1, 1);
    rd(1'b0, 1'b0, 4, 1'b1);
    rd(1'b1, 1'b1, -1, 1'b1);
    rd(1'b0, 1'b0, -1, 1'b0);
    rd(1'b1, 1'b1, 2, 1'b0);
    // Three bytes while stalled: two buffered, one pending, none lost
    stall <= 1'b1;
    frame(8'h02, 1'b0, -1, 2);
    @(negedge clk);
    chk8("rx_overrun", 8'h00, {7'h00, rx_overrun});
    @(posedge clk);
    stall <= 1'b0;
    busy <= 1'b1;
    frame(8'hc7, 1'b1, -1, 0);
    @(negedge clk);
    chk8("standby_busy", 8'h00, {7'h00, standby});
    @(posedge clk);
    busy <= 1'b0;
    repeat (4) @(negedge clk);
    chk8("standby_idle", 8'h01, {7'h00, standby});
    @(posedge clk);
    wp_n <= 1'b0;
    repeat (8) @(negedge clk);
    chk8("write_lock", 8'h01, {7'h00, write_lock});
    @(posedge clk);
    wp_n <= 1'b1;
    repeat (8) @(negedge clk);
    chk8("write_unlock", 8'h00, {7'h00, write_lock});
    chk8("rx_left", 8'h00, 8'(exp_q.size()));
    conclude();
  end

  // About 2200 cycles are needed; 20000 means a hang
  initial begin
    #2000000;
    error_cnt++;
    conclude();
  end
endmodule
